// ==== irs_pkg.sv ====
package irs_pkg;

  // ----------------------------------------
  // register map, byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADR_MASK = 8'h00;
  localparam logic [7:0] ADR_CTRL = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_TOP = 8'h0C;

  // status and control field positions
  localparam int CTRL_DBG_BIT = 0;
  localparam int STAT_DIS_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  localparam int STAT_DEPTH_LSB = 4;
  localparam int STAT_OVF_BIT = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // sequencing constants
  // ----------------------------------------
  localparam int STK_DEPTH = 8;
  localparam int LAT_HW = 8;
  localparam int LAT_SW = 4;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_NMI = 16'h0024;
  localparam logic [15:0] VEC_HW_BASE = 16'h0002;
  localparam logic [15:0] VEC_STEP = 16'h0002;

  // kind of instruction retiring this cycle
  typedef enum logic [2:0] {
    K_NONE, K_EN, K_DIS, K_RET, K_CALL, K_POP, K_PUSH
  } irs_kind_type;

  typedef enum logic {ST_IDLE, ST_WAIT} irs_state_type;

endpackage

// ==== irs_sequencer.sv ====
// Function
// - entry saves only the incremented program counter
// - eight-entry return stack, push on entry
// - one entry reserved while debugging is active
// - stack to memory pop, memory push
// - enable instruction plus next finish first
// - hold off after return one instruction
// - protected return pops before new push
// - maskable needs mask bit and cleared disable
// - hardware interrupt: eight cycles, fetch ninth
// - software interrupt: at least four cycles
// - drain pipeline before vector fetch
// - wait states extend latency
// - hold grant postpones external vector fetch
// - repeat loop locks out all but reset
// - reset immediate, nonmaskable may be delayed
// - push even when stack is full
// - nonmaskable goes to 24h, sets disable
// - maskable acceptance sets disable bit
`timescale 1ns/1ps
`default_nettype none

module irs_sequencer #(
  parameter int NIRQ = 6,
  parameter int DEPTH = irs_pkg::STK_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_input_low,
  input wire logic nmi_req,
  input wire logic [NIRQ-1:0] hw_req,
  input wire logic sw_req,
  input wire logic [15:0] sw_vector,
  input wire logic sw_sets_disable,
  input wire logic retire,
  input wire irs_pkg::irs_kind_type retire_kind,
  input wire logic [15:0] retire_pc,
  input wire logic [15:0] mem_word,
  input wire logic [15:0] next_pc,
  input wire logic pipe_empty,
  input wire logic pipe_protect,
  input wire logic wait_state,
  input wire logic bus_hold_grant,
  input wire logic vector_external,
  input wire logic repeat_active,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic drain_req,
  output logic global_irq_disable_bit,
  output logic [15:0] stack_top,
  output logic [3:0] stack_depth,
  output logic stack_overflow
);

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, bmask;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic bvalid_r, bvalid_nxt, awready_r, awready_nxt, wready_r, wready_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [NIRQ-1:0] mask_r, mask_nxt;
  logic dbg_r, dbg_nxt, ovf_clr;
  logic wr_do;

  logic [15:0] stk_r [DEPTH];
  logic [15:0] stk_nxt [DEPTH];
  logic [3:0] depth_r, depth_nxt;
  logic ovf_r, ovf_nxt, dis_r, dis_nxt;
  irs_pkg::irs_state_type st_r, st_nxt;

  // write channel: address and data taken in either order
  always_comb
  begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt = w_hold_r;
    w_data_nxt = w_data_r;
    w_strb_nxt = w_strb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    mask_nxt = mask_r;
    dbg_nxt = dbg_r;
    ovf_clr = 1'b0;
    for (int b = 0; b < 4; b++)
    begin
      bmask[b*8 +: 8] = {8{w_strb_r[b]}};
    end
    if (s_axi_awvalid && awready_r)
    begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r)
    begin
      w_hold_nxt = 1'b1;
      w_data_nxt = s_axi_wdata;
      w_strb_nxt = s_axi_wstrb;
    end
    wr_do = aw_hold_r && w_hold_r && !bvalid_r;
    if (wr_do)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = irs_pkg::RESP_OKAY;
      unique case (aw_addr_r)
        irs_pkg::ADR_MASK:
          mask_nxt = NIRQ'((32'(mask_r) & ~bmask) | (w_data_r & bmask));
        irs_pkg::ADR_CTRL:
          if (w_strb_r[0])
            dbg_nxt = w_data_r[irs_pkg::CTRL_DBG_BIT];
        irs_pkg::ADR_STAT:
          ovf_clr = w_strb_r[1] && w_data_r[irs_pkg::STAT_OVF_BIT];
        irs_pkg::ADR_TOP: ;
        default: bresp_nxt = irs_pkg::RESP_SLVERR;
      endcase
    end
    else if (bvalid_r && s_axi_bready)
    begin
      bvalid_nxt = 1'b0;
    end
    awready_nxt = !aw_hold_nxt;
    wready_nxt = !w_hold_nxt;
  end

  // read channel: one read at a time, answer one cycle after address
  always_comb
  begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = irs_pkg::RESP_OKAY;
      rdata_nxt = 32'h0000_0000;
      unique case (s_axi_araddr)
        irs_pkg::ADR_MASK: rdata_nxt = 32'(mask_r);
        irs_pkg::ADR_CTRL: rdata_nxt[irs_pkg::CTRL_DBG_BIT] = dbg_r;
        irs_pkg::ADR_STAT:
        begin
          rdata_nxt[irs_pkg::STAT_DIS_BIT] = dis_r;
          rdata_nxt[irs_pkg::STAT_BUSY_BIT] = (st_r == irs_pkg::ST_WAIT);
          rdata_nxt[irs_pkg::STAT_DEPTH_LSB +: 4] = depth_r;
          rdata_nxt[irs_pkg::STAT_OVF_BIT] = ovf_r;
        end
        irs_pkg::ADR_TOP: rdata_nxt = 32'(stk_r[0]);
        default: rresp_nxt = irs_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_r && s_axi_rready)
    begin
      rvalid_nxt = 1'b0;
    end
    arready_nxt = !rvalid_nxt;
  end

  // ----------------------------------------
  // interrupt acceptance and return stack
  // ----------------------------------------
  logic [3:0] cnt_r, cnt_nxt, cap;
  logic [15:0] vec_r, vec_nxt, vaddr_r, vaddr_nxt;
  logic sdis_r, sdis_nxt, fetch_r, fetch_nxt;
  logic blk_en_r, blk_en_nxt, blk_ret_r, blk_ret_nxt, rst_prev_r;
  logic blk, take, pop_en, push_en;
  logic [15:0] push_val;
  logic [NIRQ-1:0] hw_cand;
  logic [15:0] hw_idx;

  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    vec_nxt = vec_r;
    sdis_nxt = sdis_r;
    fetch_nxt = 1'b0;
    vaddr_nxt = vaddr_r;
    dis_nxt = dis_r;
    take = 1'b0;
    hw_idx = 16'h0000;
    // window opens at the enable or return retire edge itself, extended by protection
    blk = blk_en_r || blk_ret_r || pipe_protect || repeat_active
          || (retire && (retire_kind == irs_pkg::K_EN || retire_kind == irs_pkg::K_RET));
    hw_cand = hw_req & mask_r & {NIRQ{!dis_r}};
    for (int i = NIRQ - 1; i >= 0; i--)
    begin
      if (hw_cand[i])
        hw_idx = 16'(i);
    end
    // the instruction right after enable or return clears the window
    blk_en_nxt = retire ? (retire_kind == irs_pkg::K_EN) : blk_en_r;
    blk_ret_nxt = retire ? (retire_kind == irs_pkg::K_RET) : blk_ret_r;
    if (retire && retire_kind == irs_pkg::K_EN)
      dis_nxt = 1'b0;
    if (retire && retire_kind == irs_pkg::K_DIS)
      dis_nxt = 1'b1;
    unique case (st_r)
      irs_pkg::ST_IDLE:
        if (!blk)
        begin
          if (nmi_req)
          begin
            st_nxt = irs_pkg::ST_WAIT;
            vec_nxt = irs_pkg::VEC_NMI;
            cnt_nxt = 4'(irs_pkg::LAT_HW - 1);
            sdis_nxt = 1'b1;
          end
          else if (|hw_cand)
          begin
            st_nxt = irs_pkg::ST_WAIT;
            vec_nxt = irs_pkg::VEC_HW_BASE + 16'(hw_idx * irs_pkg::VEC_STEP);
            cnt_nxt = 4'(irs_pkg::LAT_HW - 1);
            sdis_nxt = 1'b1;
          end
          else if (sw_req)
          begin
            st_nxt = irs_pkg::ST_WAIT;
            vec_nxt = sw_vector;
            cnt_nxt = 4'(irs_pkg::LAT_SW - 1);
            sdis_nxt = sw_sets_disable;
          end
        end
      irs_pkg::ST_WAIT:
        if (cnt_r != 4'h0)
          cnt_nxt = cnt_r - 4'h1;
        // drained, no wait state, bus not held away, no repeat loop
        else if (pipe_empty && !retire && !wait_state && !repeat_active
                 && !(bus_hold_grant && vector_external))
        begin
          take = 1'b1;
          st_nxt = irs_pkg::ST_IDLE;
          fetch_nxt = 1'b1;
          vaddr_nxt = vec_r;
          if (sdis_r)
            dis_nxt = 1'b1;
        end
    endcase
    // reset aborts whatever is pending, no drain
    if (!reset_input_low)
    begin
      st_nxt = irs_pkg::ST_IDLE;
      dis_nxt = 1'b1;
      blk_en_nxt = 1'b0;
      blk_ret_nxt = 1'b0;
      take = 1'b0;
      fetch_nxt = 1'b0;
    end
    else if (!rst_prev_r)
    begin
      fetch_nxt = 1'b1;
      vaddr_nxt = irs_pkg::VEC_RESET;
      st_nxt = irs_pkg::ST_IDLE; // restart cycle accepts nothing
    end
  end

  // return stack: pop of a retiring return lands before any push
  always_comb
  begin
    stk_nxt = stk_r;
    depth_nxt = depth_r;
    ovf_nxt = ovf_r;
    // debug keeps one entry back; free for nesting when idle
    cap = dbg_r ? 4'(DEPTH - 1) : 4'(DEPTH);
    pop_en = retire && (retire_kind == irs_pkg::K_RET || retire_kind == irs_pkg::K_POP);
    push_en = take || (retire && (retire_kind == irs_pkg::K_CALL
                                  || retire_kind == irs_pkg::K_PUSH));
    // only the incremented counter is saved on entry
    push_val = take ? next_pc :
               (retire_kind == irs_pkg::K_PUSH ? mem_word : retire_pc);
    if (pop_en)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        stk_nxt[i] = stk_r[i+1];
      stk_nxt[DEPTH-1] = 16'h0000;
      if (depth_r != 4'h0)
        depth_nxt = depth_r - 4'h1;
    end
    else if (push_en)
    begin
      // full stack still takes the push; oldest entry falls off the end
      for (int i = DEPTH - 1; i > 0; i--)
        stk_nxt[i] = stk_r[i-1];
      stk_nxt[0] = push_val;
      if (depth_r >= cap)
        ovf_nxt = 1'b1;
      else
        depth_nxt = depth_r + 4'h1;
    end
    // a new overflow beats a software clear in the same cycle
    if (ovf_clr && !(push_en && !pop_en && depth_r >= cap))
      ovf_nxt = 1'b0;
  end

  // ----------------------------------------
  // state registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= irs_pkg::RESP_OKAY;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= irs_pkg::RESP_OKAY;
      mask_r <= '0;
      dbg_r <= 1'b0;
      st_r <= irs_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      vec_r <= 16'h0000;
      sdis_r <= 1'b0;
      fetch_r <= 1'b0;
      vaddr_r <= irs_pkg::VEC_RESET;
      dis_r <= 1'b1;
      blk_en_r <= 1'b0;
      blk_ret_r <= 1'b0;
      rst_prev_r <= 1'b1;
      depth_r <= 4'h0;
      ovf_r <= 1'b0;
      for (int i = 0; i < DEPTH; i++)
        stk_r[i] <= 16'h0000;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
      mask_r <= mask_nxt;
      dbg_r <= dbg_nxt;
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      vec_r <= vec_nxt;
      sdis_r <= sdis_nxt;
      fetch_r <= fetch_nxt;
      vaddr_r <= vaddr_nxt;
      dis_r <= dis_nxt;
      blk_en_r <= blk_en_nxt;
      blk_ret_r <= blk_ret_nxt;
      rst_prev_r <= reset_input_low;
      depth_r <= depth_nxt;
      ovf_r <= ovf_nxt;
      stk_r <= stk_nxt;
    end
  end

  // outputs straight from flip-flops
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign vector_fetch = fetch_r;
  assign vector_addr = vaddr_r;
  assign drain_req = (st_r == irs_pkg::ST_WAIT);
  assign global_irq_disable_bit = dis_r;
  assign stack_top = stk_r[0];
  assign stack_depth = depth_r;
  assign stack_overflow = ovf_r;

endmodule

`default_nettype wire

// ==== irs_src_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module irs_src_model #(
  parameter int N = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic vector_fetch,
  input wire logic [N-1:0] raise,
  output logic [N-1:0] req
);
  logic [N-1:0] req_r;
  logic [N-1:0] req_nxt;
  // level request held until a vector fetch, then dropped
  always_comb
  begin
    req_nxt = req_r | raise;
    if (vector_fetch) req_nxt = raise;
  end
  // registered so a request never changes inside a cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn) req_r <= '0;
    else req_r <= req_nxt;
  end
  // dropped in the fetch cycle itself, else the same request is taken twice
  assign req = req_r & ~{N{vector_fetch}};
endmodule
`default_nettype wire

// ==== irs_sequencer_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module irs_sequencer_monitor #(
  parameter int NIRQ = 6,
  parameter int DEPTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_input_low,
  input wire logic nmi_req,
  input wire logic sw_req,
  input wire logic retire,
  input wire irs_pkg::irs_kind_type retire_kind,
  input wire logic [15:0] retire_pc,
  input wire logic [15:0] next_pc,
  input wire logic pipe_empty,
  input wire logic wait_state,
  input wire logic bus_hold_grant,
  input wire logic vector_external,
  input wire logic repeat_active,
  input wire logic vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic drain_req,
  input wire logic global_irq_disable_bit,
  input wire logic [15:0] stack_top,
  input wire logic [3:0] stack_depth,
  input wire logic stack_overflow
);
  // ----------------------------------------
  // sequencing properties
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_hwlat; $rose(drain_req) && !sw_req |-> !vector_fetch [*8]; endproperty
  a_hwlat: assert property (p_hwlat) else $error("vector too early");
  property p_swlat; $rose(drain_req) |-> !vector_fetch [*4]; endproperty
  a_swlat: assert property (p_swlat) else $error("soft vector too early");
  property p_stall; !pipe_empty || wait_state || bus_hold_grant && vector_external
    |=> !vector_fetch || vector_addr == 16'h0000; endproperty
  a_stall: assert property (p_stall) else $error("fetch in stall");
  property p_rpt; repeat_active && !drain_req |=> !drain_req; endproperty
  a_rpt: assert property (p_rpt) else $error("taken in repeat");
  property p_rst; $rose(reset_input_low) |=> vector_fetch && vector_addr == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("no reset vector");
  property p_abort; !reset_input_low |=> !drain_req && global_irq_disable_bit; endproperty
  a_abort: assert property (p_abort) else $error("reset not immediate");
  property p_nmi; vector_fetch && vector_addr == 16'h0024 |-> global_irq_disable_bit; endproperty
  a_nmi: assert property (p_nmi) else $error("nmi left enabled");
  property p_mask; global_irq_disable_bit && !nmi_req && !sw_req && !drain_req
    |=> !drain_req; endproperty
  a_mask: assert property (p_mask) else $error("taken while disabled");
  // the window opens at the retire edge itself, so acceptance must wait
  property p_win; retire && !drain_req && (retire_kind == irs_pkg::K_EN
    || retire_kind == irs_pkg::K_RET) |=> !drain_req; endproperty
  a_win: assert property (p_win) else $error("taken in window");
  property p_push; retire && retire_kind == irs_pkg::K_CALL && stack_depth < 4'h7
    |=> stack_top == $past(retire_pc) && stack_depth == $past(stack_depth) + 4'h1; endproperty
  a_push: assert property (p_push) else $error("call push wrong");
  property p_pop; retire && stack_depth != 4'h0 && (retire_kind == irs_pkg::K_RET
    || retire_kind == irs_pkg::K_POP) |=> stack_depth == $past(stack_depth) - 4'h1; endproperty
  a_pop: assert property (p_pop) else $error("pop wrong");
  property p_full; retire && retire_kind == irs_pkg::K_CALL && stack_depth == DEPTH
    |=> stack_overflow && stack_depth == DEPTH; endproperty
  a_full: assert property (p_full) else $error("full push wrong");
  property p_entry; vector_fetch && vector_addr != 16'h0000 |-> stack_top == $past(next_pc);
  endproperty
  a_entry: assert property (p_entry) else $error("entry push wrong");
endmodule
bind irs_sequencer irs_sequencer_monitor #(.NIRQ(NIRQ), .DEPTH(DEPTH)) u_mon (.aclk, .aresetn,
  .reset_input_low, .nmi_req, .sw_req, .retire, .retire_kind, .retire_pc, .next_pc, .pipe_empty,
  .wait_state, .bus_hold_grant, .vector_external, .repeat_active, .vector_fetch, .vector_addr,
  .drain_req, .global_irq_disable_bit, .stack_top, .stack_depth, .stack_overflow);
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic aclk = 0, aresetn = 0, core_rst_n = 1, retire = 0, prot = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, vfetch, drain, dis, ovf;
  logic [7:0] awaddr = 0, araddr = 0, raise = 0, req;
  logic [31:0] wdata = 0, rdata, rdv;
  logic [1:0] bresp, rresp, rr;
  logic [3:0] stall = 0, depth;
  logic [15:0] rpc = 0, npc = 16'h1234, vaddr, top;
  irs_pkg::irs_kind_type kind = irs_pkg::K_NONE;
  int errors = 0, check_count = 0, lat;
  irs_sequencer dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .reset_input_low(core_rst_n), .nmi_req(req[6]), .hw_req(req[5:0]),
    .sw_req(req[7]), .sw_vector(16'h0022), .sw_sets_disable(1'b0), .retire(retire),
    .retire_kind(kind), .retire_pc(rpc), .mem_word(rpc), .next_pc(npc),
    .pipe_empty(!stall[2]), .pipe_protect(prot), .wait_state(stall[0]),
    .bus_hold_grant(stall[1]), .vector_external(1'b1), .repeat_active(stall[3]),
    .vector_fetch(vfetch), .vector_addr(vaddr), .drain_req(drain),
    .global_irq_disable_bit(dis), .stack_top(top), .stack_depth(depth), .stack_overflow(ovf));
  // sources: hw 0..5, nmi pin 6, software request 7
  irs_src_model #(.N(8)) src (.aclk(aclk), .aresetn(aresetn), .vector_fetch(vfetch),
    .raise(raise), .req(req));
  // free-running core clock
  initial
  begin
    forever #20 aclk = ~aclk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    rr = bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rdv = rdata;
    rr = rresp;
  endtask
  task automatic rt(input irs_pkg::irs_kind_type k, input logic [15:0] p);
    @(posedge aclk);
    retire <= 1'b1;
    kind <= k;
    rpc <= p;
    @(posedge aclk);
    retire <= 1'b0;
    #1;
  endtask
  task automatic pulse(input int b);
    @(posedge aclk);
    raise <= 8'h01 << b;
    @(posedge aclk);
    raise <= 8'h00;
  endtask
  // bounded wait, so a lost request shows as a mismatch, not a hang
  task automatic wfetch();
    lat = 0;
    while (lat < 80 && vfetch !== 1'b1)
    begin
      @(posedge aclk);
      lat++;
      if (lat == 1) stall <= 4'h0;
      #1;
    end
  endtask
  // stalls held for sc cycles from the first request cycle
  task automatic fire(input int b, input logic [3:0] st, input int sc, input logic [15:0] va);
    logic [3:0] d;
    d = depth;
    pulse(b);
    stall <= st;
    lat = 0;
    while (lat < 80 && vfetch !== 1'b1)
    begin
      @(posedge aclk);
      lat++;
      if (lat == sc) stall <= 4'h0;
      #1;
    end
    chk(vaddr === va, "vector address");
    chk(top === npc, "return address");
    chk(depth === (d == 4'h8 ? d : d + 4'h1), "entry depth");
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(irs_pkg::ADR_STAT);
    chk(rdv === 32'h0000_0001, "status after reset");
    rd(8'h10);
    chk(rr === irs_pkg::RESP_SLVERR && rdv === 32'h0, "unmapped read");
    wr(irs_pkg::ADR_MASK, 32'h0000_003F);
    chk(rr === irs_pkg::RESP_OKAY, "write response");
    wr(8'h10, 32'h0000_0000);
    chk(rr === irs_pkg::RESP_SLVERR, "unmapped write");
    rd(irs_pkg::ADR_MASK);
    chk(rdv === 32'h0000_003F, "mask readback");
  endtask
  task automatic t_stack();
    for (int i = 0; i < 9; i++) rt(irs_pkg::K_CALL, 16'h0100 + 16'(i));
    chk(depth === 4'h8 && ovf === 1'b1 && top === 16'h0108, "full push");
    rd(irs_pkg::ADR_TOP);
    chk(rdv === 32'h0000_0108, "top read");
    wr(irs_pkg::ADR_STAT, 32'h0000_0100);
    rd(irs_pkg::ADR_STAT);
    chk(rdv === 32'h0000_0081, "overflow clear");
    rt(irs_pkg::K_POP, 16'h0000);
    chk(depth === 4'h7 && top === 16'h0107, "pop to memory");
    rt(irs_pkg::K_PUSH, 16'hBEEF);
    chk(depth === 4'h8 && top === 16'hBEEF, "push from memory");
    rt(irs_pkg::K_RET, 16'h0000);
    rt(irs_pkg::K_RET, 16'h0000);
    chk(depth === 4'h6 && top === 16'h0106, "return pops");
    wr(irs_pkg::ADR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 2; i++) rt(irs_pkg::K_CALL, 16'h0200);
    chk(depth === 4'h7 && ovf === 1'b1, "debug keeps a spare");
    wr(irs_pkg::ADR_CTRL, 32'h0000_0000);
    wr(irs_pkg::ADR_STAT, 32'h0000_0100);
    for (int i = 0; i < 7; i++) rt(irs_pkg::K_RET, 16'h0000);
    chk(depth === 4'h0 && ovf === 1'b0, "unwound");
  endtask
  task automatic t_irq();
    rt(irs_pkg::K_EN, 16'h0000);
    rt(irs_pkg::K_NONE, 16'h0000);
    fire(0, 4'h0, 0, 16'h0002);
    chk(lat === 9 && dis === 1'b1, "hw latency");
    pulse(1);
    repeat (20) @(posedge aclk);
    chk(drain === 1'b0, "disabled hw ignored");
    rt(irs_pkg::K_EN, 16'h0000);
    repeat (4) @(posedge aclk);
    chk(drain === 1'b0, "enable window");
    rt(irs_pkg::K_NONE, 16'h0000);
    wfetch();
    chk(vfetch === 1'b1 && vaddr === 16'h0004, "pending hw taken");
    rt(irs_pkg::K_RET, 16'h0000);
    pulse(6);
    repeat (4) @(posedge aclk);
    chk(drain === 1'b0, "return window");
    rt(irs_pkg::K_NONE, 16'h0000);
    wfetch();
    chk(vaddr === 16'h0024 && dis === 1'b1, "nmi after window");
    fire(6, 4'h0, 0, 16'h0024);
    chk(lat === 9, "nmi latency");
    fire(7, 4'h0, 0, 16'h0022);
    chk(lat === 5, "soft latency");
  endtask
  // protection after the return window keeps the hold-off going
  task automatic t_protect();
    rt(irs_pkg::K_RET, 16'h0000);
    pulse(6);
    prot <= 1'b1;
    rt(irs_pkg::K_NONE, 16'h0000);
    repeat (4) @(posedge aclk);
    chk(drain === 1'b0, "protect holds off");
    prot <= 1'b0;
    wfetch();
    chk(vfetch === 1'b1 && vaddr === 16'h0024, "taken after protect");
  endtask
  // stalls must cover the count-zero cycle to show; fetch one cycle after release, nine cycles after the repeat loop ends
  task automatic t_stall();
    for (int k = 0; k < 3; k++)
    begin
      fire(6, 4'h1 << k, 12, 16'h0024);
      chk(lat === 13, "stall extends latency");
    end
    fire(6, 4'h8, 20, 16'h0024);
    chk(lat === 29, "repeat lockout");
  endtask
  task automatic t_core_reset();
    pulse(6);
    core_rst_n <= 1'b0;
    repeat (3) @(posedge aclk);
    #1;
    chk(drain === 1'b0 && dis === 1'b1, "reset aborts");
    @(posedge aclk);
    core_rst_n <= 1'b1;
    @(posedge aclk);
    #1;
    chk(vfetch === 1'b1 && vaddr === 16'h0000, "reset vector");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_stack();
    t_irq();
    t_protect();
    t_stall();
    t_core_reset();
    results();
  end
  // span is many times the expected run
  initial
  begin
    #2000000;
    errors++;
    results();
  end
endmodule
`default_nettype wire
